/* hdl/adcmc_cfg.svh */
// Offsets, field positions, reset values and timing counts for the converter control block.
`ifndef ADCMC_CFG_SVH
`define ADCMC_CFG_SVH
`define ADCMC_IDX_MODE 2'h0
`define ADCMC_IDX_OUT 2'h1
`define ADCMC_BIT_CLKSRC 5
`define ADCMC_BIT_INTYPE 4
`define ADCMC_BIT_MODEHI 3
`define ADCMC_BIT_MODELO 2
`define ADCMC_BIT_TRIGSEL 6
`define ADCMC_BIT_FMT 2
`define ADCMC_MODE_ZMASK 8'h00
`define ADCMC_OUT_ZMASK 8'h80
`define ADCMC_MODE_RESET 8'h00
`define ADCMC_OUT_RESET 8'h00
`define ADCMC_PIN_IDLE 15'h7800
`define ADCMC_SMP_DLY_MONO 4'h2
`define ADCMC_SMP_DLY_DUAL 4'h7
`define ADCMC_CONV_EXT 4'h5
`define ADCMC_CONV_INT 4'h6
`define ADCMC_DCONV_EXT 4'hA
`define ADCMC_DCONV_INT 4'hC
`define ADCMC_OSC_PERIOD_NS 125
`define ADCMC_REF_PERIOD_NS 5
`define ADCMC_OSC_DIV (`ADCMC_OSC_PERIOD_NS / `ADCMC_REF_PERIOD_NS)
`endif

/* hdl/adcmc_control.sv */
// Mode, channel and trigger sequencing control of the four-input converter.
`timescale 1ns/1ps
`default_nettype none
`include "adcmc_cfg.svh"
module adcmc_control
  import adcmc_pkg::*;
#(
  parameter int OSC_DIV = `ADCMC_OSC_DIV
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic convStartN,
  input wire logic extClkIn,
  input wire logic [9:0] busIn,
  output logic [9:0] busOut,
  output logic busOe,
  output logic intOut,
  output logic intOe,
  input wire logic [9:0] resultIn,
  input wire logic softPowerDown,
  output logic [3:0] chanEnable,
  output logic diffInputs,
  output logic bipolarResult,
  output logic extClkSel,
  output logic sampling,
  output logic converting,
  output logic convClkTick
);
  typedef struct packed {
    logic [7:0] modeCfg;
    logic [7:0] outCfg;
    logic [14:0] pinPrev;
    adcmc_state_type state;
    logic [3:0] tickCnt;
    logic [3:0] smpCnt;
    logic smpArmed;
    logic sampling;
    logic intLow;
    logic [9:0] resFirst;
    logic [9:0] resSecond;
    logic readSecond;
    logic cfgPtr;
    logic pdPrev;
    logic [4:0] divCnt;
    logic [9:0] busOut;
  } adcmc_ctl_type;

  localparam logic [4:0] DIV_LAST = 5'(OSC_DIV - 1);

  generate
    if (OSC_DIV < 2 || OSC_DIV > 32)
    begin : g_bad_div
      $error("Oscillator divider must lie between 2 and 32.");
    end
  endgenerate

  function automatic logic [3:0] chanDecode(input logic [7:0] cfg);
    logic [3:0] en;
    en = 4'h0;
    if (cfg[`ADCMC_BIT_MODELO] && cfg[`ADCMC_BIT_INTYPE])
      en = 4'hF;
    else if (cfg[`ADCMC_BIT_MODELO])
      en = cfg[0] ? 4'hA : 4'h5;
    else if (cfg[`ADCMC_BIT_INTYPE])
      en = cfg[1] ? 4'hC : 4'h3;
    else
      en = 4'h1 << cfg[1:0];
    return en;
  endfunction : chanDecode

  function automatic logic [3:0] convLen(input logic [7:0] cfg);
    logic ext;
    ext = cfg[`ADCMC_BIT_CLKSRC];
    if (cfg[`ADCMC_BIT_MODELO])
      return ext ? `ADCMC_DCONV_EXT : `ADCMC_DCONV_INT;
    return ext ? `ADCMC_CONV_EXT : `ADCMC_CONV_INT;
  endfunction : convLen

  logic rstMeta;
  logic rstN;
  logic [14:0] pinS;
  adcmc_ctl_type st;
  adcmc_ctl_type next_st;
  logic csS;
  logic rdS;
  logic wrS;
  logic cstS;
  logic [9:0] busS;
  logic wrRise;
  logic rdFall;
  logic rdRise;
  logic csRise;
  logic cstFall;
  logic cstRise;
  logic convTick;
  logic dual;
  logic cont;
  logic trigRd;
  logic monoRd;
  logic startConv;
  logic intClear;
  logic [3:0] curLen;
  logic [9:0] word;
  adcmc_mode_type mode;

  // Reset is released through two flip-flops.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  adcmc_pin_sync #(.WIDTH(15), .IDLE(`ADCMC_PIN_IDLE)) u_sync (
    .clk(ref_clk),
    .rstN(rstN),
    .pinIn({csN, rdN, wrN, convStartN, extClkIn, busIn}),
    .syncOut(pinS)
  );

  assign csS = pinS[14];
  assign rdS = pinS[13];
  assign wrS = pinS[12];
  assign cstS = pinS[11];
  assign busS = pinS[9:0];
  assign wrRise = wrS && !st.pinPrev[12];
  assign rdFall = !rdS && st.pinPrev[13];
  assign rdRise = rdS && !st.pinPrev[13];
  assign csRise = csS && !st.pinPrev[14];
  assign cstFall = !cstS && st.pinPrev[11];
  assign cstRise = cstS && !st.pinPrev[11];

  // The internal oscillator counts from the trigger, the external clock is edge-detected.
  assign convTick = st.modeCfg[`ADCMC_BIT_CLKSRC] ? (pinS[10] && !st.pinPrev[10]) : (st.divCnt == DIV_LAST);

  assign mode = adcmc_mode_type'({st.modeCfg[`ADCMC_BIT_MODEHI], st.modeCfg[`ADCMC_BIT_MODELO]});
  assign dual = st.modeCfg[`ADCMC_BIT_MODELO];
  assign cont = st.modeCfg[`ADCMC_BIT_MODEHI];
  // Continuous modes use the read strobe, dual interrupt the start pin, mono interrupt either.
  assign trigRd = cont || (mode == MONO_INT && !st.outCfg[`ADCMC_BIT_TRIGSEL]);
  assign monoRd = (mode == MONO_INT) && trigRd;
  assign startConv = (trigRd && rdFall && !softPowerDown) || (!trigRd && cstRise);
  assign intClear = st.intLow && (csRise || (monoRd ? rdRise : rdFall));
  assign curLen = convLen(st.modeCfg);

  always_comb
  begin
    next_st = st;
    next_st.pinPrev = pinS;
    next_st.pdPrev = softPowerDown;
    if (st.divCnt == DIV_LAST)
      next_st.divCnt = 5'h00;
    else
      next_st.divCnt = st.divCnt + 5'h01;
    // A register changes only when a full write strobe ends with chip select low.
    if (wrRise && !csS)
    begin
      case (busS[9:8])
        `ADCMC_IDX_MODE: next_st.modeCfg = busS[7:0] & ~`ADCMC_MODE_ZMASK;
        `ADCMC_IDX_OUT: next_st.outCfg = busS[7:0] & ~`ADCMC_OUT_ZMASK;
        default: next_st.outCfg = st.outCfg;
      endcase
      next_st.sampling = 1'b1;
      next_st.smpArmed = 1'b0;
    end
    if (cstFall && !trigRd)
    begin
      next_st.sampling = 1'b1;
      next_st.smpArmed = 1'b0;
    end
    if (st.smpArmed && convTick)
    begin
      if (st.smpCnt == 4'h1)
      begin
        next_st.sampling = 1'b1;
        next_st.smpArmed = 1'b0;
      end
      else
        next_st.smpCnt = st.smpCnt - 4'h1;
    end
    case (st.state)
      ST_IDLE: next_st.state = ST_IDLE;
      ST_CONV:
      begin
        if (convTick)
        begin
          next_st.tickCnt = st.tickCnt + 4'h1;
          if (dual && st.tickCnt == (curLen >> 1) - 4'h1)
            next_st.resFirst = resultIn;
          if (st.tickCnt == curLen - 4'h1)
          begin
            if (dual)
              next_st.resSecond = resultIn;
            else
              next_st.resFirst = resultIn;
            next_st.state = cont ? ST_IDLE : ST_DONE;
            next_st.intLow = !cont;
          end
        end
      end
      ST_DONE: next_st.state = ST_DONE;
      default: next_st.state = ST_IDLE;
    endcase
    if (intClear)
    begin
      next_st.intLow = 1'b0;
      next_st.state = ST_IDLE;
    end
    if (rdRise && dual && !softPowerDown)
      next_st.readSecond = !st.readSecond;
    if (startConv)
    begin
      next_st.state = ST_CONV;
      next_st.tickCnt = 4'h0;
      next_st.divCnt = 5'h00;
      next_st.sampling = 1'b0;
      next_st.readSecond = 1'b0;
      next_st.intLow = 1'b0;
      if (trigRd)
      begin
        next_st.smpArmed = 1'b1;
        next_st.smpCnt = (mode == DUAL_CONT) ? `ADCMC_SMP_DLY_DUAL : `ADCMC_SMP_DLY_MONO;
      end
    end
    if (softPowerDown && !st.pdPrev)
      next_st.cfgPtr = 1'b0;
    else if (softPowerDown && rdRise)
      next_st.cfgPtr = 1'b1;
    word = st.readSecond ? st.resSecond : st.resFirst;
    if (st.modeCfg[`ADCMC_BIT_INTYPE] && !st.outCfg[`ADCMC_BIT_FMT])
      word[9] = !word[9];
    if (softPowerDown)
      next_st.busOut = st.cfgPtr ? {`ADCMC_IDX_OUT, st.outCfg} : {`ADCMC_IDX_MODE, st.modeCfg};
    else
      next_st.busOut = word;
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      st <= '0;
      st.modeCfg <= `ADCMC_MODE_RESET;
      st.outCfg <= `ADCMC_OUT_RESET;
      st.pinPrev <= `ADCMC_PIN_IDLE;
      st.state <= ST_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign busOut = st.busOut;
  assign busOe = !csS && !rdS && (softPowerDown || !monoRd || st.intLow);
  assign intOut = 1'b0;
  assign intOe = st.intLow;
  assign chanEnable = chanDecode(st.modeCfg);
  assign diffInputs = st.modeCfg[`ADCMC_BIT_INTYPE];
  assign bipolarResult = st.modeCfg[`ADCMC_BIT_INTYPE];
  assign extClkSel = st.modeCfg[`ADCMC_BIT_CLKSRC];
  assign sampling = st.sampling;
  assign converting = (st.state == ST_CONV);
  assign convClkTick = convTick;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstN);

  sequence rdStart;
    trigRd && rdFall && !softPowerDown;
  endsequence
  sequence modeWrite;
    wrRise && !csS && busS[9:8] == `ADCMC_IDX_MODE;
  endsequence

  mode_write_a: assert property (modeWrite |=> st.modeCfg == ($past(busS[7:0]) & ~`ADCMC_MODE_ZMASK))
    else $error("Mode register did not take the bus value.");
  zero_bits_a: assert property ((st.outCfg & `ADCMC_OUT_ZMASK) == 8'h00)
    else $error("A zero-only bit holds one.");
  single_se_a: assert property (!dual && !diffInputs |-> chanEnable[st.modeCfg[1:0]] && $onehot(chanEnable))
    else $error("Wrong single-ended channel.");
  single_diff_a: assert property (!dual && diffInputs |-> chanEnable == (st.modeCfg[1] ? 4'hC : 4'h3))
    else $error("Wrong differential pair.");
  dual_se_a: assert property (dual && !diffInputs |-> chanEnable == (st.modeCfg[0] ? 4'hA : 4'h5))
    else $error("Wrong dual single-ended pair.");
  dual_diff_a: assert property (dual && diffInputs |-> chanEnable == 4'hF)
    else $error("Dual differential must use both pairs.");
  clk_src_a: assert property (modeWrite |=> extClkSel == $past(busS[`ADCMC_BIT_CLKSRC]))
    else $error("Clock source not switched at write end.");
  pd_ignore_a: assert property (softPowerDown && trigRd && rdFall && st.state == ST_IDLE |=> st.state == ST_IDLE)
    else $error("Read fall in power-down started a conversion.");
  cfg_read_a: assert property (softPowerDown && st.pdPrev && rdRise |=> st.cfgPtr ##1 busOut[7:0] == st.outCfg)
    else $error("Second power-down read is not the output register.");
  rd_start_a: assert property (rdStart |=> converting && !sampling && st.smpArmed
    && st.smpCnt == ((mode == DUAL_CONT) ? `ADCMC_SMP_DLY_DUAL : `ADCMC_SMP_DLY_MONO))
    else $error("Read trigger did not start the sequence.");
  cst_start_a: assert property (!trigRd && cstRise |=> converting && !sampling)
    else $error("Start pin rise did not start conversion.");
  conv_len_a: assert property (converting && next_st.state == ST_DONE |-> convTick && st.tickCnt == curLen - 4'h1)
    else $error("Conversion ended at the wrong clock count.");
  int_clear_a: assert property (st.intLow && monoRd && rdRise |=> !intOe)
    else $error("Read rise did not clear the interrupt.");
endmodule : adcmc_control
`default_nettype wire

/* hdl/adcmc_dummy_unused.sv */
// Unused.

/* hdl/adcmc_pin_sync.sv */
// Two-stage synchroniser for the asynchronous pins of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adcmc_pin_sync
  import adcmc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
)
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } adcmc_sync_type;

  adcmc_sync_type st;
  adcmc_sync_type next_st;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("Synchroniser width must be at least one.");
    end
  endgenerate

  always_comb
  begin
    next_st.meta = pinIn;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      st <= {IDLE, IDLE};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign syncOut = st.stable;
endmodule : adcmc_pin_sync
`default_nettype wire

/* hdl/adcmc_pkg.sv */
// Types shared by the converter control block.
package adcmc_pkg;
  typedef enum logic [1:0] {MONO_INT, DUAL_INT, MONO_CONT, DUAL_CONT} adcmc_mode_type;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} adcmc_state_type;
endpackage : adcmc_pkg

/* testbench/adcmc_host_model.sv */
// Host processor model driving the parallel pins of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adcmc_host_model
  import adcmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [9:0] busOut,
  input wire logic busOe,
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic convStartN,
  output logic [9:0] busIn
);
  logic [9:0] hostData;
  logic hostDrive;

  // A released bus shows the inverse of the last driven word.
  assign busIn = busOe ? busOut : (hostDrive ? hostData : ~hostData);

  initial
  begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    convStartN = 1'b1;
    hostData = 10'h000;
    hostDrive = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  task automatic wr(input logic [1:0] idx, input logic [7:0] data, input logic sel);
    @(negedge ref_clk);
    csN = ~sel;
    hostData = {idx, data};
    hostDrive = 1'b1;
    wrN = 1'b0;
    idle(4);
    wrN = 1'b1;
    idle(3);
    hostDrive = 1'b0;
    idle(4);
  endtask : wr

  task automatic rd_low;
    @(negedge ref_clk);
    csN = 1'b0;
    rdN = 1'b0;
  endtask : rd_low

  task automatic rd_high;
    @(negedge ref_clk);
    rdN = 1'b1;
  endtask : rd_high

  task automatic desel;
    @(negedge ref_clk);
    csN = 1'b1;
  endtask : desel

  task automatic cst_set(input logic level);
    @(negedge ref_clk);
    convStartN = level;
  endtask : cst_set

  task automatic conversion_start_pin;
    @(negedge ref_clk);
    convStartN = 1'b0;
    idle(4);
    convStartN = 1'b1;
  endtask : conversion_start_pin
endmodule : adcmc_host_model
`default_nettype wire

/* testbench/tb.sv */
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb
  import adcmc_pkg::*;
;
  logic ref_clk, arst_n, extClkIn, softPowerDown, csN, rdN, wrN, convStartN;
  logic busOe, intOe, intOut, diffInputs, bipolarResult, extClkSel, sampling, converting, convClkTick;
  logic [9:0] busIn, busOut, resultIn;
  logic [3:0] chanEnable;
  int fails, check_count;

  adcmc_host_model host (.ref_clk(ref_clk), .busOut(busOut), .busOe(busOe), .csN(csN), .rdN(rdN),
    .wrN(wrN), .convStartN(convStartN), .busIn(busIn));

  adcmc_control #(.OSC_DIV(2)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .csN(csN), .rdN(rdN),
    .wrN(wrN), .convStartN(convStartN), .extClkIn(extClkIn), .busIn(busIn), .busOut(busOut),
    .busOe(busOe), .intOut(intOut), .intOe(intOe), .resultIn(resultIn), .softPowerDown(softPowerDown),
    .chanEnable(chanEnable), .diffInputs(diffInputs), .bipolarResult(bipolarResult),
    .extClkSel(extClkSel), .sampling(sampling), .converting(converting), .convClkTick(convClkTick));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    extClkIn = 1'b0;
    forever #20 extClkIn = ~extClkIn;
  end

  task automatic close_out;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    #50000;
    fails++;
    close_out();
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    chk({9'h000, got}, {9'h000, exp});
  endtask : chk_bit

  function automatic logic [3:0] exp_chan(input logic [1:0] md, input logic it, input logic [1:0] cs);
    if (md[0] && it)
      return 4'hF;
    if (md[0])
      return cs[0] ? 4'hA : 4'h5;
    if (it)
      return cs[1] ? 4'hC : 4'h3;
    return 4'h1 << cs;
  endfunction : exp_chan

  function automatic logic [9:0] conv_len(input logic dual, input logic src);
    return dual ? (src ? 10'h00A : 10'h00C) : (src ? 10'h005 : 10'h006);
  endfunction : conv_len

  task automatic meas(output int n, output int s);
    int k;
    n = 0;
    s = 0;
    k = 0;
    while (converting !== 1'b1 && k < 300)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk_bit(sampling, 1'b0);
    while (converting === 1'b1 && k < 900)
    begin
      if (convClkTick === 1'b1)
      begin
        n++;
        if (sampling !== 1'b1)
          s++;
      end
      @(negedge ref_clk);
      k++;
    end
  endtask : meas

  task automatic wait_int;
    int k;
    k = 0;
    while (intOe !== 1'b1 && k < 300)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk_bit(intOe, 1'b1);
    chk_bit(intOut, 1'b0);
  endtask : wait_int

  initial
  begin
    int n;
    logic [7:0] md;
    logic [7:0] ob;
    logic [9:0] r;
    int s;
    logic sel;
    logic smp;
    logic [7:0] acc;
    arst_n = 1'b0;
    softPowerDown = 1'b0;
    resultIn = 10'h000;
    fails = 0;
    check_count = 0;
    r = 10'($urandom(78315));
    repeat (12) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({6'h00, chanEnable}, 10'h001);
    chk_bit(intOe, 1'b0);
    chk_bit(busOe, 1'b0);
    acc = 8'h00;
    smp = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      md = {2'($urandom()), 1'($urandom()), 5'(i)};
      sel = 1'($urandom());
      softPowerDown = 1'($urandom());
      host.wr(2'h0, md, sel);
      if (sel)
        acc = md;
      smp = smp | sel;
      chk({6'h00, chanEnable}, {6'h00, exp_chan(acc[3:2], acc[4], acc[1:0])});
      chk({7'h00, diffInputs, bipolarResult, extClkSel}, {7'h00, acc[4], acc[4], acc[5]});
      chk_bit(sampling, smp);
    end
    softPowerDown = 1'b0;
    host.wr(2'h0, ~acc, 1'b0);
    host.wr(2'h2, ~acc, 1'b1);
    chk({6'h00, chanEnable}, {6'h00, exp_chan(acc[3:2], acc[4], acc[1:0])});
    for (int i = 0; i < 4; i++)
    begin
      host.wr(2'h0, {2'h0, i[0], 1'b0, 1'b1, i[1], 2'h0}, 1'b1);
      host.wr(2'h1, 8'h04, 1'b1);
      host.cst_set(1'($urandom()));
      host.rd_low();
      meas(n, s);
      chk(10'(n), conv_len(i[1], i[0]));
      chk(10'(s), i[1] ? 10'h007 : 10'h002);
      host.rd_high();
      host.cst_set(1'b1);
      host.idle(30);
    end
    host.wr(2'h0, 8'h00, 1'b1);
    host.wr(2'h1, 8'h04, 1'b1);
    r = 10'($urandom());
    resultIn = r;
    host.rd_low();
    wait_int();
    host.idle(3);
    chk_bit(busOe, 1'b1);
    chk(busOut, r);
    host.rd_high();
    host.idle(5);
    chk_bit(intOe, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      host.wr(2'h0, i[0] ? 8'h04 : 8'h00, 1'b1);
      host.wr(2'h1, 8'h44, 1'b1);
      r = 10'($urandom());
      resultIn = r;
      host.desel();
      host.conversion_start_pin();
      meas(n, s);
      chk(10'(n), conv_len(i[0], 1'b0));
      wait_int();
      host.rd_low();
      host.idle(5);
      chk_bit(intOe, 1'b0);
      chk_bit(busOe, 1'b1);
      chk(busOut, r);
      host.rd_high();
      host.idle(8);
    end
    md = 8'($urandom());
    ob = 8'($urandom()) | 8'h80;
    host.wr(2'h0, md, 1'b1);
    host.wr(2'h1, ob, 1'b1);
    softPowerDown = 1'b1;
    host.idle(4);
    host.rd_low();
    host.idle(5);
    chk(busOut, {2'h0, md});
    chk_bit(converting, 1'b0);
    host.rd_high();
    host.idle(4);
    host.rd_low();
    host.idle(5);
    chk(busOut, {2'h1, ob & 8'h7F});
    host.rd_high();
    softPowerDown = 1'b0;
    close_out();
  end
endmodule : tb
`default_nettype wire
